// ==== src/cpu_status_flags_consts.svh ====
// register offsets, bit positions and reset values of the status flags block
`ifndef CPU_STATUS_FLAGS_CONSTS_SVH
`define CPU_STATUS_FLAGS_CONSTS_SVH

`define CSF_OFS_STATE 2'h0
`define CSF_OFS_CORE 2'h1
`define CSF_OFS_INTC 2'h2

`define CSF_BIT_CARRY 0
`define CSF_BIT_ZERO 1
`define CSF_BIT_WRAP 2
`define CSF_BIT_NEG 3
`define CSF_BIT_LOOP 4
`define CSF_BIT_PRIO_LO 5
`define CSF_BIT_PRIO_HI 7
`define CSF_BIT_COMB_CLIP 11
`define CSF_BIT_B_CLIP 12
`define CSF_BIT_A_CLIP 13
`define CSF_BIT_PRIO_MSB 3
`define CSF_BIT_NEST_DIS 15

`define CSF_RST_PRIO 3'h0
`define CSF_PRIO_TOP 3'h7
`define CSF_ZERO_WORD 16'h0000

`endif

// ==== src/cpu_status_flags_pkg.sv ====
// types shared by the status flags block
package cpu_status_flags_pkg;
  typedef logic [15:0] word_t;
  typedef logic [2:0]  prio_t;
  typedef enum logic [0:0] {
    OP_ADD = 1'b0,
    OP_SUB = 1'b1
  } alu_op_t;
endpackage

// ==== src/cpu_status_flags.sv ====
// processor status word low byte, clip flags and priority output
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "cpu_status_flags_consts.svh"

// How it works
// - three-bit priority, level seven masks users
// - upper control bit extends priority to 8-15
// - upper priority bit masks all user interrupts
// - nesting disable makes priority field read-only
// - bit 4 follows single-instruction loop activity
// - bit 3 set on negative result
// - bit 2 set on signed overflow
// - bit 1 set on zero result, nonzero result clears
// - bit 0 holds carry out of msb
// - status write loads each clip flag from its bit while bit 11 is set, else clears both
module cpu_status_flags
  import cpu_status_flags_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire logic [1:0] ADDR,
  input  wire word_t      WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output word_t           RDATA,
  input  wire logic       ALU_GO,
  input  wire alu_op_t    ALU_OP,
  input  wire word_t      ALU_A,
  input  wire word_t      ALU_B,
  input  wire logic       LOOP_BUSY,
  input  wire logic       ACC_A_SAT,
  input  wire logic       ACC_B_SAT,
  output word_t           ALU_Y,
  output logic [3:0]      PRIO,
  output logic            USER_IRQ_OFF
);

  prio_t       prio;
  logic        prio_msb;
  logic        nest_dis;
  logic        loop_flag;
  logic        neg;
  logic        wrap;
  logic        zero;
  logic        carry;
  logic        clip_a;
  logic        clip_b;
  logic        wr_state;
  logic        wr_core;
  logic        wr_intc;
  logic [16:0] sum;
  word_t       b_eff;
  logic        wrap_now;
  logic [3:0]  eff_prio;
  word_t       state_word;

  function automatic word_t pack_state(
    input prio_t p,
    input logic  lp,
    input logic  n,
    input logic  v,
    input logic  z,
    input logic  c,
    input logic  sa,
    input logic  sb
  );
    word_t w;
    w = `CSF_ZERO_WORD;
    w[`CSF_BIT_PRIO_HI:`CSF_BIT_PRIO_LO] = p;
    w[`CSF_BIT_LOOP] = lp;
    w[`CSF_BIT_NEG] = n;
    w[`CSF_BIT_WRAP] = v;
    w[`CSF_BIT_ZERO] = z;
    w[`CSF_BIT_CARRY] = c;
    w[`CSF_BIT_A_CLIP] = sa;
    w[`CSF_BIT_B_CLIP] = sb;
    w[`CSF_BIT_COMB_CLIP] = sa | sb;
    return w;
  endfunction

  assign wr_state = WR && (ADDR == `CSF_OFS_STATE);
  assign wr_core  = WR && (ADDR == `CSF_OFS_CORE);
  assign wr_intc  = WR && (ADDR == `CSF_OFS_INTC);

  // subtract as a + ~b + 1, so carry means no borrow
  assign b_eff = (ALU_OP == OP_SUB) ? ~ALU_B : ALU_B;
  assign sum   = {1'b0, ALU_A} + {1'b0, b_eff} + {16'h0000, ALU_OP == OP_SUB};
  // sign flips while both operands share a sign
  assign wrap_now = (ALU_A[15] == b_eff[15]) && (sum[15] != ALU_A[15]);

  assign eff_prio   = {prio_msb, prio};
  assign state_word = pack_state(prio, loop_flag, neg, wrap, zero, carry,
                                 clip_a, clip_b);

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      prio <= `CSF_RST_PRIO;
    else if (wr_state && !nest_dis)
      prio <= WDATA[`CSF_BIT_PRIO_HI:`CSF_BIT_PRIO_LO];
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      prio_msb <= 1'b0;
      nest_dis <= 1'b0;
    end
    else
    begin
      if (wr_core)
      begin
        prio_msb <= WDATA[`CSF_BIT_PRIO_MSB];
      end
      if (wr_intc)
      begin
        nest_dis <= WDATA[`CSF_BIT_NEST_DIS];
      end
    end
  end

  // loop flag is read-only; the sequencer owns it
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      loop_flag <= 1'b0;
    else
      loop_flag <= LOOP_BUSY;
  end

  // an alu update in the same cycle beats a software write
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      neg   <= 1'b0;
      wrap  <= 1'b0;
      zero  <= 1'b0;
      carry <= 1'b0;
      ALU_Y <= `CSF_ZERO_WORD;
    end
    else if (ALU_GO)
    begin
      neg   <= sum[15];
      wrap  <= wrap_now;
      zero  <= (sum[15:0] == `CSF_ZERO_WORD);
      carry <= sum[16];
      ALU_Y <= sum[15:0];
    end
    else if (wr_state)
    begin
      neg   <= WDATA[`CSF_BIT_NEG];
      wrap  <= WDATA[`CSF_BIT_WRAP];
      zero  <= WDATA[`CSF_BIT_ZERO];
      carry <= WDATA[`CSF_BIT_CARRY];
    end
  end

  // a whole-word write is the only safe path; saturation set wins
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      clip_a <= 1'b0;
      clip_b <= 1'b0;
    end
    else
    begin
      if (ACC_A_SAT)
      begin
        clip_a <= 1'b1;
      end
      else if (wr_state)
      begin
        clip_a <= WDATA[`CSF_BIT_A_CLIP] & WDATA[`CSF_BIT_COMB_CLIP];
      end
      if (ACC_B_SAT)
      begin
        clip_b <= 1'b1;
      end
      else if (wr_state)
      begin
        clip_b <= WDATA[`CSF_BIT_B_CLIP] & WDATA[`CSF_BIT_COMB_CLIP];
      end
    end
  end

  // outputs lag the stored state by one edge
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      PRIO         <= 4'h0;
      USER_IRQ_OFF <= 1'b0;
    end
    else
    begin
      PRIO         <= eff_prio;
      USER_IRQ_OFF <= prio_msb || (prio == `CSF_PRIO_TOP);
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      RDATA <= `CSF_ZERO_WORD;
    else if (RD)
    begin
      case (ADDR)
        `CSF_OFS_STATE: RDATA <= state_word;
        `CSF_OFS_CORE:  RDATA <= {12'h000, prio_msb, 3'h0};
        `CSF_OFS_INTC:  RDATA <= {nest_dis, 15'h0000};
        default:        RDATA <= `CSF_ZERO_WORD;
      endcase
    end
    else
      RDATA <= `CSF_ZERO_WORD;
  end

  property p_prio_out;
    @(posedge CLK) disable iff (RST)
    1 |=> PRIO == $past(eff_prio);
  endproperty
  a_prio_out: assert property (p_prio_out)
    else $error("priority output mismatch");

  property p_top_level;
    @(posedge CLK) disable iff (RST)
    (prio == `CSF_PRIO_TOP) |=> USER_IRQ_OFF;
  endproperty
  a_top_level: assert property (p_top_level)
    else $error("level seven did not mask users");

  property p_msb_mask;
    @(posedge CLK) disable iff (RST)
    prio_msb |=> USER_IRQ_OFF && PRIO[3];
  endproperty
  a_msb_mask: assert property (p_msb_mask)
    else $error("upper priority bit did not mask users");

  property p_prio_lock;
    @(posedge CLK) disable iff (RST)
    wr_state && nest_dis |=> $stable(prio);
  endproperty
  a_prio_lock: assert property (p_prio_lock)
    else $error("priority written while locked");

  property p_loop;
    @(posedge CLK) disable iff (RST)
    1 |=> loop_flag == $past(LOOP_BUSY);
  endproperty
  a_loop: assert property (p_loop)
    else $error("loop flag does not follow loop");

  property p_neg;
    @(posedge CLK) disable iff (RST)
    ALU_GO |=> neg == ALU_Y[15];
  endproperty
  a_neg: assert property (p_neg)
    else $error("negative flag wrong");

  property p_wrap;
    @(posedge CLK) disable iff (RST)
    ALU_GO |=> wrap == $past(wrap_now);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("overflow flag wrong");

  property p_zero_keep;
    @(posedge CLK) disable iff (RST)
    !ALU_GO && !wr_state |=> $stable(zero);
  endproperty
  a_zero_keep: assert property (p_zero_keep)
    else $error("zero flag changed without cause");

  property p_zero_set;
    @(posedge CLK) disable iff (RST)
    ALU_GO |=> zero == (ALU_Y == `CSF_ZERO_WORD);
  endproperty
  a_zero_set: assert property (p_zero_set)
    else $error("zero flag does not match result");

  property p_carry;
    @(posedge CLK) disable iff (RST)
    ALU_GO |=> carry == $past(sum[16]);
  endproperty
  a_carry: assert property (p_carry)
    else $error("carry flag wrong");

  property p_clip_clear;
    @(posedge CLK) disable iff (RST)
    wr_state && !WDATA[`CSF_BIT_COMB_CLIP] && !ACC_A_SAT && !ACC_B_SAT
      |=> !clip_a && !clip_b;
  endproperty
  a_clip_clear: assert property (p_clip_clear)
    else $error("combined clip clear failed");

  property p_clip_set;
    @(posedge CLK) disable iff (RST)
    ACC_A_SAT |=> clip_a ##1 (clip_a || $past(wr_state));
  endproperty
  a_clip_set: assert property (p_clip_set)
    else $error("saturation event lost");

  property p_read;
    @(posedge CLK) disable iff (RST)
    RD && (ADDR == `CSF_OFS_STATE) |=> RDATA == $past(state_word);
  endproperty
  a_read: assert property (p_read)
    else $error("status read data wrong");

  property p_cv_loop;
    @(posedge CLK) disable iff (RST)
    LOOP_BUSY ##1 loop_flag ##1 !loop_flag;
  endproperty
  c_cv_loop: cover property (p_cv_loop);

  property p_cv_lock;
    @(posedge CLK) disable iff (RST)
    wr_state && nest_dis;
  endproperty
  c_cv_lock: cover property (p_cv_lock);

  property p_cv_clip;
    @(posedge CLK) disable iff (RST)
    clip_a ##1 wr_state ##1 !clip_a;
  endproperty
  c_cv_clip: cover property (p_cv_clip);

  property p_cv_wrap;
    @(posedge CLK) disable iff (RST)
    ALU_GO && wrap_now;
  endproperty
  c_cv_wrap: cover property (p_cv_wrap);

endmodule // cpu_status_flags

// ==== test/testbench.sv ====
// self-checking bench of the status flags block
`timescale 1ns/1ps
`include "cpu_status_flags_consts.svh"
module testbench
  import cpu_status_flags_pkg::*;
;
  logic       clk;
  logic       rst;
  logic [1:0] addr;
  word_t      wdata;
  logic       wr_s;
  logic       rd_s;
  word_t      rdata;
  logic       alu_go;
  alu_op_t    alu_op;
  word_t      alu_a;
  word_t      alu_b;
  logic       loop_busy;
  logic       acc_a_sat;
  logic       acc_b_sat;
  word_t      alu_y;
  logic [3:0] prio;
  logic       user_irq_off;
  int         err_count = 0;
  int         samples_checked = 0;
  int         cycles = 0;
  // bench copy of the stored state
  prio_t      prio_s = 3'h0;
  logic [3:0] flg = 4'h0;
  logic       ca = 1'b0;
  logic       cb = 1'b0;
  logic       nest = 1'b0;

  cpu_status_flags u_cpu_status_flags (
    .CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata),
    .ALU_GO(alu_go), .ALU_OP(alu_op), .ALU_A(alu_a), .ALU_B(alu_b), .LOOP_BUSY(loop_busy),
    .ACC_A_SAT(acc_a_sat), .ACC_B_SAT(acc_b_sat), .ALU_Y(alu_y), .PRIO(prio),
    .USER_IRQ_OFF(user_irq_off));

  always #20 clk = ~clk;

  function automatic word_t st_exp();
    return {2'h0, ca, cb, ca | cb, 3'h0, prio_s, loop_busy, flg};
  endfunction

  // expected {negative, overflow, zero, carry, result} from plain integer sums
  function automatic logic [19:0] alu_exp(input alu_op_t op, input word_t a, input word_t b);
    int    sr;
    word_t y;
    logic  c;
    if (op == OP_SUB)
    begin
      sr = int'($signed(a)) - int'($signed(b));
      c  = (a >= b); // no borrow
    end
    else
    begin
      sr = int'($signed(a)) + int'($signed(b));
      c  = (int'(a) + int'(b)) > 65535;
    end
    y = word_t'(sr);
    return {y[15], (sr > 32767) || (sr < -32768), y == 16'h0000, c, y};
  endfunction

  task automatic print_verdict();
    $display("checked %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input string what, input word_t seen, input word_t exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [1:0] a, input word_t d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask

  // status write, model follows the documented side effects
  task automatic wr_st(input word_t d);
    wr(`CSF_OFS_STATE, d);
    if (!nest)
      prio_s = d[7:5];
    flg = d[3:0];
    ca = d[13] & d[11];
    cb = d[12] & d[11];
  endtask

  // read data only stands in the cycle after the strobe
  task automatic rd_chk(input string what, input logic [1:0] a, input word_t exp);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    check(what, rdata, exp);
  endtask

  task automatic alu(input alu_op_t op, input word_t a, input word_t b);
    logic [19:0] e;
    e = alu_exp(op, a, b);
    @(posedge clk);
    alu_go <= 1'b1;
    alu_op <= op;
    alu_a  <= a;
    alu_b  <= b;
    @(posedge clk);
    alu_go <= 1'b0;
    #1;
    flg = e[19:16];
    check("alu_y", alu_y, e[15:0]);
    rd_chk("flags", `CSF_OFS_STATE, st_exp());
  endtask

  task automatic sat_pulse(input logic b_side);
    @(posedge clk);
    acc_a_sat <= ~b_side;
    acc_b_sat <= b_side;
    @(posedge clk);
    acc_a_sat <= 1'b0;
    acc_b_sat <= 1'b0;
    if (b_side)
      cb = 1'b1;
    else
      ca = 1'b1;
    rd_chk("clip", `CSF_OFS_STATE, st_exp());
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      err_count++;
      print_verdict();
    end
  end

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    addr = 2'h0;
    wdata = 16'h0000;
    wr_s = 1'b0;
    rd_s = 1'b0;
    alu_go = 1'b0;
    alu_op = OP_ADD;
    alu_a = 16'h0000;
    alu_b = 16'h0000;
    loop_busy = 1'b0;
    acc_a_sat = 1'b0;
    acc_b_sat = 1'b0;
    void'($urandom(32'h6de8c3d5));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd_chk("status", `CSF_OFS_STATE, 16'h0000);
    rd_chk("core", `CSF_OFS_CORE, 16'h0000);
    rd_chk("intc", `CSF_OFS_INTC, 16'h0000);
    rd_chk("unmapped", 2'h3, 16'h0000);
    @(posedge clk);
    #1;
    check("rdata idle", rdata, 16'h0000);
    // corners: wrap to negative, exact zero, borrow, zero held until the next alu op
    alu(OP_ADD, 16'h7FFF, 16'h0001);
    alu(OP_SUB, 16'h1234, 16'h1234);
    rd_chk("sticky", `CSF_OFS_STATE, st_exp());
    alu(OP_SUB, 16'h0000, 16'h0001);
    alu(OP_SUB, 16'h8000, 16'h0001);
    alu(OP_ADD, 16'hFFFF, 16'h0001);
    repeat (40)
    begin
      @(posedge clk);
      loop_busy <= 1'($urandom);
      alu(alu_op_t'($urandom % 2), word_t'($urandom), word_t'($urandom));
    end
    @(posedge clk);
    loop_busy <= 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      wr(`CSF_OFS_CORE, {12'h000, i[3], 3'h0});
      wr_st({8'h00, i[2:0], 1'b0, flg});
      repeat (2) @(posedge clk);
      #1;
      check("prio", {12'h000, prio}, 16'(i[3:0]));
      check("irq_off", {15'h0, user_irq_off}, 16'(i[3] | (i[2:0] == 3'h7)));
      rd_chk("core", `CSF_OFS_CORE, {12'h000, i[3], 3'h0});
    end
    wr(`CSF_OFS_INTC, 16'h8000);
    nest = 1'b1;
    rd_chk("intc set", `CSF_OFS_INTC, 16'h8000);
    wr_st(16'h00A5);
    rd_chk("locked", `CSF_OFS_STATE, st_exp());
    wr(`CSF_OFS_INTC, 16'h0000);
    nest = 1'b0;
    wr_st(16'h0040);
    rd_chk("unlocked", `CSF_OFS_STATE, st_exp());
    sat_pulse(1'b0);
    sat_pulse(1'b1);
    wr_st(16'h3000);
    rd_chk("clip cleared", `CSF_OFS_STATE, st_exp());
    wr_st(16'h2800);
    rd_chk("clip a", `CSF_OFS_STATE, st_exp());
    wr_st(16'h1800);
    rd_chk("clip b", `CSF_OFS_STATE, st_exp());
    // saturation in the same cycle as a clearing write must survive
    @(posedge clk);
    acc_a_sat <= 1'b1;
    addr      <= `CSF_OFS_STATE;
    wdata     <= 16'h0000;
    wr_s      <= 1'b1;
    @(posedge clk);
    acc_a_sat <= 1'b0;
    wr_s      <= 1'b0;
    prio_s = 3'h0;
    flg = 4'h0;
    ca = 1'b1;
    cb = 1'b0;
    rd_chk("set wins", `CSF_OFS_STATE, st_exp());
    print_verdict();
  end
endmodule // testbench
